// [rtl/wfe_consts.vh]
// Register offsets, field positions and reset values of the waveform engine
// register bank. Included by the engine and the register bank; the synchroniser does not include it.
`ifndef WFE_CONSTS_VH
`define WFE_CONSTS_VH

`define WFE_ADDR_W 16
`define WFE_OFF_EP8_FLAG_SELECT 16'hE6EA
`define WFE_OFF_EP8_STOP_ON_FLAG 16'hE6EB
`define WFE_OFF_EP8_TRIGGER 16'hE6EC
`define WFE_OFF_DATA_HIGH 16'hE6F0
`define WFE_OFF_DATA_LOW_TRIG 16'hE6F1
`define WFE_OFF_DATA_LOW_QUIET 16'hE6F2
`define WFE_OFF_READY_CONFIG 16'hE6F3
`define WFE_OFF_READY_STATUS 16'hE6F4
`define WFE_OFF_ABORT 16'hE6F5
`define WFE_OFF_ENGINE_STATUS 16'hE6F6

`define WFE_RST_FLAG_SELECT 2'h0
`define WFE_RST_STOP_ON_FLAG 1'h0
`define WFE_RST_READY_CONFIG 3'h0
`define WFE_RST_BYTE 8'h00

`define WFE_CFG_LSB 5
`define WFE_CFG_MSB 7
`define WFE_STAT_RDY_MSB 5
`define WFE_SEL_MSB 1
`define WFE_STOP_BIT 0
`define WFE_INTERNAL_READY_BIT 2
`define WFE_UNMAPPED_READ 8'h00

`define WFE_KIND_SINGLE 1'h0
`define WFE_KIND_EP8 1'h1

`endif

// [rtl/wfe_sync2.v]
// Two-stage synchroniser for a vector of pin levels.
// Assumes the inputs are asynchronous to mclk; first stage feeds only second.
module wfe_sync2 #(
	parameter WIDTH = 6
) (
	input wire mclk,
	input wire rst,
	input wire [WIDTH-1:0] async_in,
	output wire [WIDTH-1:0] sync_out
);

	reg [WIDTH-1:0] meta_q;
	reg [WIDTH-1:0] sync_q;

	always @(posedge mclk or posedge rst) begin
		if (rst) begin
			meta_q <= {WIDTH{1'b0}};
			sync_q <= {WIDTH{1'b0}};
		end else begin
			meta_q <= async_in;
			sync_q <= meta_q;
		end
	end

	assign sync_out = sync_q;

endmodule // wfe_sync2

// [rtl/wfe_engine.v]
// Waveform transaction sequencer: runs one transaction on the pins.
// Assumes start and abort are single-cycle pulses from the register bank.
`include "wfe_consts.vh"

module wfe_engine #(
	parameter STEPS = 4
) (
	input wire mclk,
	input wire rst,
	input wire start,
	input wire kind,
	input wire dir_read,
	input wire abort,
	input wire stop_flag,
	input wire ready,
	output wire busy,
	output reg done,
	output reg [2:0] ctl_q,
	output reg drive_q,
	output reg capture
);

	localparam IDLE = 2'b00;
	localparam SETUP = 2'b01;
	localparam WAIT = 2'b10;
	localparam FINISH = 2'b11;

	reg [1:0] state_q;
	reg [1:0] state_d;
	reg [7:0] step_q;
	reg kind_q;
	reg dir_q;

	assign busy = (state_q != IDLE);

	always @* begin
		state_d = state_q;
		case (state_q)
			IDLE: if (start) state_d = SETUP;
			SETUP: state_d = WAIT;
			WAIT: if (ready && step_q == STEPS - 1) state_d = FINISH;
			FINISH: state_d = IDLE;
			default: state_d = IDLE;
		endcase
		if (abort && state_q != IDLE)
			state_d = IDLE;
		else if (kind_q == `WFE_KIND_EP8 && stop_flag && state_q == WAIT)
			state_d = FINISH;
	end

	always @(posedge mclk or posedge rst) begin
		if (rst) begin
			state_q <= IDLE;
			step_q <= 8'h00;
			kind_q <= 1'b0;
			dir_q <= 1'b0;
			ctl_q <= 3'h0;
			drive_q <= 1'b0;
			done <= 1'b0;
			capture <= 1'b0;
		end else begin
			state_q <= state_d;
			done <= (state_q != IDLE) && (state_d == IDLE);
			capture <= (state_q == WAIT) && (state_d == FINISH) && dir_q;
			if (state_q == IDLE && start) begin
				kind_q <= kind;
				dir_q <= dir_read;
			end
			if (state_q == WAIT && ready)
				step_q <= step_q + 8'h01;
			else if (state_q == IDLE)
				step_q <= 8'h00;
			ctl_q <= {state_d == FINISH, state_d == WAIT, state_d == SETUP};
			drive_q <= (state_d != IDLE) && !dir_q && !(state_q == IDLE);
		end
	end

endmodule // wfe_engine

// [rtl/wfe_regs.v]
// Register bank of the waveform engine: flag select, stop-on-flag, trigger,
// single-transfer data, ready configuration and status, and abort.
// Assumes a byte-wide register port on mclk; read data one cycle later.
`include "wfe_consts.vh"

module wfe_regs #(
	parameter STEPS = 4,
	parameter WIDE_BUS = 1
) (
	input wire mclk,
	input wire rst,
	input wire [15:0] reg_addr,
	input wire [7:0] reg_wdata,
	input wire reg_wr,
	input wire reg_rd,
	output reg [7:0] reg_rdata,
	input wire [5:0] ready_pins,
	input wire [3:0] ep8_flags,
	input wire [15:0] bus_in,
	output reg [15:0] bus_out,
	output wire [15:0] bus_oe,
	output wire [2:0] ctl_out,
	output wire engine_busy,
	output wire engine_done
);

	////////////////////////////////////////////////////////////////////////
	// Pin synchronisation

	wire [5:0] ready_sync;
	wire [3:0] flags_sync;
	wire [15:0] bus_sync;

	wfe_sync2 #(.WIDTH(6)) u_sync_rdy (
		.mclk(mclk),
		.rst(rst),
		.async_in(ready_pins),
		.sync_out(ready_sync)
	);

	wfe_sync2 #(.WIDTH(4)) u_sync_flg (
		.mclk(mclk),
		.rst(rst),
		.async_in(ep8_flags),
		.sync_out(flags_sync)
	);

	wfe_sync2 #(.WIDTH(16)) u_sync_bus (
		.mclk(mclk),
		.rst(rst),
		.async_in(bus_in),
		.sync_out(bus_sync)
	);

	////////////////////////////////////////////////////////////////////////
	// Registers

	reg [1:0] flag_sel_q;
	reg stop_en_q;
	reg [2:0] ready_cfg_q;
	reg [7:0] data_low_q;
	reg [7:0] data_high_q;
	reg read_pending_q;

	wire hit_sel = (reg_addr == `WFE_OFF_EP8_FLAG_SELECT);
	wire hit_stop = (reg_addr == `WFE_OFF_EP8_STOP_ON_FLAG);
	wire hit_trig8 = (reg_addr == `WFE_OFF_EP8_TRIGGER);
	wire hit_hi = (reg_addr == `WFE_OFF_DATA_HIGH);
	wire hit_lox = (reg_addr == `WFE_OFF_DATA_LOW_TRIG);
	wire hit_lonox = (reg_addr == `WFE_OFF_DATA_LOW_QUIET);
	wire hit_cfg = (reg_addr == `WFE_OFF_READY_CONFIG);
	wire hit_stat = (reg_addr == `WFE_OFF_READY_STATUS);
	wire hit_abort = (reg_addr == `WFE_OFF_ABORT);
	wire hit_eng = (reg_addr == `WFE_OFF_ENGINE_STATUS);

	wire abort_req = reg_wr && hit_abort;
	wire single_req = (reg_wr || reg_rd) && hit_lox;
	wire ep8_req = reg_wr && hit_trig8;
	wire start = (single_req || ep8_req) && !engine_busy;

	// Internal ready replaces the pins; otherwise only ready 0 is used
	wire ready_used = ready_cfg_q[`WFE_INTERNAL_READY_BIT] ? 1'b1 : ready_sync[0];
	wire stop_flag = stop_en_q && flags_sync[flag_sel_q];
	wire capture;
	wire drive;

	// mclk stands in for the interface clock; no second domain here
	wfe_engine #(.STEPS(STEPS)) u_engine (
		.mclk(mclk),
		.rst(rst),
		.start(start),
		.kind(ep8_req ? `WFE_KIND_EP8 : `WFE_KIND_SINGLE),
		.dir_read(reg_rd),
		.abort(abort_req),
		.stop_flag(stop_flag),
		.ready(ready_used),
		.busy(engine_busy),
		.done(engine_done),
		.ctl_q(ctl_out),
		.drive_q(drive),
		.capture(capture)
	);

	assign bus_oe = WIDE_BUS ? {16{drive}} : {8'h00, {8{drive}}};

	always @(posedge mclk or posedge rst) begin
		if (rst) begin
			flag_sel_q <= `WFE_RST_FLAG_SELECT;
			stop_en_q <= `WFE_RST_STOP_ON_FLAG;
			ready_cfg_q <= `WFE_RST_READY_CONFIG;
			data_low_q <= `WFE_RST_BYTE;
			data_high_q <= `WFE_RST_BYTE;
			read_pending_q <= 1'b0;
			bus_out <= 16'h0000;
		end else begin
			if (reg_wr && hit_sel)
				flag_sel_q <= reg_wdata[`WFE_SEL_MSB:0];
			if (reg_wr && hit_stop)
				stop_en_q <= reg_wdata[`WFE_STOP_BIT];
			if (reg_wr && hit_cfg)
				ready_cfg_q <= reg_wdata[`WFE_CFG_MSB:`WFE_CFG_LSB];
			if (reg_wr && hit_hi)
				data_high_q <= reg_wdata;
			if (reg_wr && hit_lox) begin
				data_low_q <= reg_wdata;
				if (start)
					bus_out <= {data_high_q, reg_wdata};
			end
			if (start)
				read_pending_q <= reg_rd;
			// Read value lands after the transaction; firmware reads quiet copy
			if (capture && read_pending_q) begin
				data_low_q <= bus_sync[7:0];
				if (WIDE_BUS != 0)
					data_high_q <= bus_sync[15:8];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Read path

	always @(posedge mclk or posedge rst) begin
		if (rst) begin
			reg_rdata <= `WFE_UNMAPPED_READ;
		end else if (reg_rd) begin
			if (hit_sel)
				reg_rdata <= {6'h00, flag_sel_q};
			else if (hit_stop)
				reg_rdata <= {7'h00, stop_en_q};
			else if (hit_hi)
				reg_rdata <= data_high_q;
			else if (hit_lox || hit_lonox)
				reg_rdata <= data_low_q;
			else if (hit_cfg)
				reg_rdata <= {ready_cfg_q, 5'h00};
			else if (hit_stat)
				reg_rdata <= {2'h0, ready_sync};
			else if (hit_eng)
				reg_rdata <= {7'h00, engine_busy};
			else
				reg_rdata <= `WFE_UNMAPPED_READ;
		end else begin
			reg_rdata <= `WFE_UNMAPPED_READ;
		end
	end

endmodule // wfe_regs

// [testbench/wfe_periph.sv]
// Model of the parallel peripheral on the waveform engine pins.
// Assumes the bank drives all data pins together (bus_oe bit 0).
module wfe_periph (
	input logic mclk,
	input logic stall,
	input logic [5:0] rdy_set,
	input logic [15:0] bus_out,
	input logic [15:0] bus_oe,
	input logic [2:0] ctl_out,
	output logic [15:0] bus_in,
	output logic [5:0] ready_pins
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [15:0] mem_q = 16'h0000;
	logic [15:0] junk_q = 16'h5A5A;
	always @(posedge mclk) begin
		junk_q <= ~junk_q;
		if (ctl_out[2] && bus_oe[0])
			mem_q <= bus_out;
	end
	// Answers inverted so capture cannot pass by echoing the write
	assign bus_in = bus_oe[0] ? bus_out : ctl_out != 3'h0 ? ~mem_q : junk_q;
	// Stall holds ready 0 low, so only stop, abort or internal ready end a wait
	assign ready_pins = {rdy_set[5:1], rdy_set[0] & !stall};
endmodule // wfe_periph

// [testbench/wfe_regs_asserts.sv]
// Port checker of the waveform engine register bank.
// Bound into wfe_regs; one clock, asynchronous reset.
module wfe_regs_chk (
	input logic mclk,
	input logic rst,
	input logic [15:0] reg_addr,
	input logic reg_wr,
	input logic reg_rd,
	input logic [7:0] reg_rdata,
	input logic [15:0] bus_oe,
	input logic [15:0] bus_out,
	input logic [2:0] ctl_out,
	input logic engine_busy,
	input logic engine_done
);
	logic wr_lo, rd_q, wr_ab, wr_t8;
	assign wr_lo = reg_wr && reg_addr == 16'hE6F1;
	assign rd_q = reg_rd && reg_addr == 16'hE6F2;
	assign wr_ab = reg_wr && reg_addr == 16'hE6F5;
	assign wr_t8 = reg_wr && reg_addr == 16'hE6EC;
	default clocking @(posedge mclk);
	endclocking
	default disable iff (rst);
	////////////////////////////////////////
	start_lo_a: assert property (wr_lo && !engine_busy |=> engine_busy)
		else $error("low byte trigger lost");
	setup_a: assert property ($rose(engine_busy) |-> ctl_out == 3'h1)
		else $error("no setup state");
	// Enable comes up one cycle after busy, once the direction is latched
	drive_a: assert property ($rose(engine_busy) && $past(wr_lo) |=>
		bus_oe == 16'hFFFF) else $error("write not driven");
	quiet_a: assert property (rd_q && !engine_busy |=> !engine_busy)
		else $error("quiet read started");
	abort_a: assert property (wr_ab && engine_busy |=>
		!engine_busy && engine_done) else $error("abort ignored");
	trig8_a: assert property (wr_t8 && !engine_busy |=> engine_busy)
		else $error("ep8 trigger lost");
	ignore_a: assert property (wr_lo && engine_busy |=>
		ctl_out != 3'h1 && $stable(bus_out)) else $error("busy retriggered");
	cfg_low_a: assert property (reg_rd && reg_addr == 16'hE6F3 |=>
		reg_rdata[4:0] == 5'h00) else $error("config low bits");
	stat_top_a: assert property (reg_rd && reg_addr == 16'hE6F4 |=>
		reg_rdata[7:6] == 2'h0) else $error("status top bits");
	done_a: assert property (engine_done |-> !engine_busy ##1 !engine_done)
		else $error("done not a pulse");
	cover property (wr_ab && engine_busy);
	cover property (wr_lo && engine_busy);
	cover property ($rose(engine_busy) && $past(wr_t8));
endmodule // wfe_regs_chk
bind wfe_regs wfe_regs_chk chk_u (.*);

// [testbench/wfe_regs_tb.sv]
// Self-checking bench of the waveform engine register bank.
// Drives the register port; wfe_periph answers on the pins.
module wfe_regs_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic mclk = 0;
	logic rst = 1;
	logic [15:0] reg_addr = 16'h0000;
	logic [7:0] reg_wdata = 8'h00;
	logic reg_wr = 0;
	logic reg_rd = 0;
	logic [7:0] reg_rdata, d;
	logic [5:0] ready_pins;
	logic [5:0] rdy_set = 6'h3F;
	logic [3:0] ep8_flags = 4'h0;
	logic stall = 0;
	logic [15:0] bus_in, bus_out, bus_oe;
	logic [2:0] ctl_out;
	logic engine_busy, engine_done;
	logic [31:0] r = 32'h8401;
	logic [15:0] zr [4] = '{16'hE6EA, 16'hE6EB, 16'hE6F3, 16'hE6E0};
	int error_cnt = 0;
	int n_tests = 0;
	int k;
	always #4 mclk = ~mclk;
	wfe_regs #(.STEPS(4), .WIDE_BUS(1)) dut_u (.*);
	wfe_periph per_u (.*);
	////////////////////////////////////////
	function automatic logic [31:0] nx(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	task automatic chk(input string n, input logic [15:0] s, e);
		n_tests++;
		if (s !== e) begin
			error_cnt++;
			$display("ERROR %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic wr(input logic [15:0] a, input logic [7:0] v);
		@(posedge mclk);
		reg_addr <= a;
		reg_wdata <= v;
		reg_wr <= 1;
		@(posedge mclk);
		reg_wr <= 0;
	endtask
	task automatic rd(input logic [15:0] a);
		@(posedge mclk);
		reg_addr <= a;
		reg_rd <= 1;
		@(posedge mclk);
		reg_rd <= 0;
		#1 d = reg_rdata;
	endtask
	// Bounded wait for the done pulse; k reaches 40 on a hang
	task automatic wdone();
		#1 k = 0;
		while (engine_done !== 1'b1 && k < 40) begin
			@(posedge mclk);
			#1 k++;
		end
	endtask
	task automatic report_and_stop();
		$display("tests %0d errors %0d", n_tests, error_cnt);
		if (error_cnt == 0 && n_tests > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	////////////////////////////////////////
	initial begin
		#20000;
		error_cnt++;
		report_and_stop();
	end
	initial begin
		repeat (4) @(posedge mclk);
		rst <= 0;
		for (int i = 0; i < 4; i++) begin
			rd(zr[i]);
			chk("reset value", d, 0);
		end
		repeat (6) begin
			r = nx(r);
			rdy_set <= r[5:0] | 6'h01;
			wr(16'hE6EA, r[7:0]);
			rd(16'hE6EA);
			chk("flag select", d, r[1:0]);
			wr(16'hE6EB, r[15:8]);
			rd(16'hE6EB);
			chk("stop enable", d, r[8]);
			wr(16'hE6F3, r[23:16]);
			rd(16'hE6F3);
			chk("ready config", d, {r[23:21], 5'h00});
			rd(16'hE6F4);
			chk("ready status", d, r[5:0] | 6'h01);
			wr(16'hE6F0, r[31:24]);
			wr(16'hE6F1, r[15:8]);
			wr(16'hE6F1, r[7:0]);
			wdone();
			chk("word sent", per_u.mem_q, {r[31:24], r[15:8]});
			rd(16'hE6F1);
			chk("low byte", d, r[7:0]);
			wdone();
			rd(16'hE6F2);
			chk("captured low", d, 8'(~r[15:8]));
			rd(16'hE6F0);
			chk("captured high", d, 8'(~r[31:24]));
		end
		stall <= 1;
		wr(16'hE6F3, 8'h00);
		for (int s = 0; s < 4; s++) begin
			ep8_flags <= 4'h1 << s;
			wr(16'hE6EA, 8'(s));
			wr(16'hE6EB, 8'h01);
			wr(16'hE6EC, r[7:0]);
			wdone();
			chk("stop on flag", k < 40, 1);
			wr(16'hE6EB, 8'h00);
			wr(16'hE6EC, 8'h00);
			repeat (20) @(posedge mclk);
			#1 chk("stalled busy", engine_busy, 1);
			rd(16'hE6F6);
			chk("engine status", d, 1);
			wr(16'hE6F5, r[15:8]);
			wdone();
			chk("abort", k < 40, 1);
		end
		// Pins still stalled: only the internal ready can finish this one
		wr(16'hE6F3, 8'h80);
		wr(16'hE6F1, r[23:16]);
		wdone();
		chk("internal ready", k < 40, 1);
		chk("internal word", per_u.mem_q, {~r[31:24], r[23:16]});
		report_and_stop();
	end
endmodule // wfe_regs_tb
